// ===== logic/nbi_pkg.sv
// Constants, opcodes and types for the NAND bus host controller
// Operation
// - One shared 8-bit bus carries commands, addresses, write data and read data.
// - Host sends five address cycles, low bits first, fixed bit map.
// - Host drives unused upper bits of cycles two and five low.
// - Opcode set: read, ID, reset, program, dual program, erases, status, random.
// - Write cycles: select low, read strobe high, at most one qualifier (none for data), pulse write strobe.
// - Reading: qualifiers low, select low, write strobe high, toggle read strobe.
// - Host holds chip select high the minimum time for standby.
// - Dual-plane program: first page A19 clear, second page A19 set; host only forces A19 on the second, first page goes as given.
package nbi_pkg;

  // ****************************************
  // Request kinds
  // ****************************************
  localparam logic [2:0] KIND_CMD = 3'h0;
  localparam logic [2:0] KIND_ADDR = 3'h1;
  localparam logic [2:0] KIND_DWR = 3'h2;
  localparam logic [2:0] KIND_DRD = 3'h3;
  localparam logic [2:0] KIND_WAIT = 3'h4;
  localparam logic [2:0] KIND_STBY = 3'h5;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_READ_GO = 8'h30;
  localparam logic [7:0] OP_ID = 8'h90;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_PROG_GO = 8'h10;
  localparam logic [7:0] OP_PROG_DUMMY = 8'h11;
  localparam logic [7:0] OP_PROG_PLANE2 = 8'h81;
  localparam logic [7:0] OP_ERASE = 8'h60;
  localparam logic [7:0] OP_ERASE_GO = 8'hd0;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_RAND_IN = 8'h85;
  localparam logic [7:0] OP_RAND_OUT = 8'h05;
  localparam logic [7:0] OP_RAND_OUT_GO = 8'he0;

  // ****************************************
  // Address map and timing
  // ****************************************
  localparam logic [31:0] PLANE_BIT = 32'h0008_0000;
  localparam logic [2:0] ADDR_LAST = 3'h4;
  localparam int CLK_PERIOD_NS = 50;
  localparam int OUT_VALID_DELAY_NS = 20;
  localparam int OUT_VALID_RAW = (OUT_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OUT_VALID_CYC = 8'((OUT_VALID_RAW < 1) ? 1 : OUT_VALID_RAW);
  localparam int STANDBY_US = 10;
  localparam logic [7:0] STANDBY_CYC = 8'((STANDBY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] BUSY_SETTLE_CYC = 8'h02;
  localparam int FIFO_WIDTH = 35;
  localparam int FIFO_DEPTH = 32;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WLO = 7'h02,
    ST_WHI = 7'h04,
    ST_RLO = 7'h08,
    ST_RHI = 7'h10,
    ST_WAIT = 7'h20,
    ST_STBY = 7'h40
  } nbi_state_type;

  typedef struct packed {
    nbi_state_type st;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic oe;
    logic rb;
    logic busy;
    logic rdy;
    logic [5:0] fill;
    logic plane2;
    logic rd_valid;
    logic [7:0] io;
    logic [7:0] rd_data;
    logic [7:0] cnt;
    logic [2:0] kind;
    logic [31:0] addr;
  } nbi_host_reg_type;

endpackage : nbi_pkg

// ===== logic/nbi_host.sv
// Request FIFO and NAND bus host sequencer
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Request FIFO
// ****************************************
module nbi_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic en_in,
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [WIDTH-1:0] push_data_in,
  output logic pop_valid_out,
  input wire logic pop_ready_in,
  output logic [WIDTH-1:0] pop_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } nbi_fifo_reg_type;

  nbi_fifo_reg_type r;
  nbi_fifo_reg_type next_r;
  logic do_push;
  logic do_pop;

  // Handshakes and flags
  assign push_ready_out = (r.count != (AW + 1)'(DEPTH));
  assign pop_valid_out = (r.count != '0);
  assign pop_data_out = r.mem[r.rp];
  assign do_push = push_valid_in && push_ready_out;
  assign do_pop = pop_valid_out && pop_ready_in;

  // Pointer and count update
  always_comb begin
    next_r = r;
    if (do_push) begin
      next_r.mem[r.wp] = push_data_in;
      next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (do_pop) begin
      next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    next_r.count = r.count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  // State register, frozen by the enable
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else if (en_in) begin
      r <= next_r;
    end
  end
endmodule : nbi_fifo

// ****************************************
// Bus host
// ****************************************
module nbi_host (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic req_valid_in,
  input wire logic [2:0] req_kind_in,
  input wire logic [31:0] req_data_in,
  output logic req_ready_out,
  input wire logic modify_en_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic busy_out,
  output logic ce_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic we_n_out,
  output logic re_n_out,
  output logic wp_n_out,
  output logic [7:0] io_out,
  output logic io_oe_out,
  input wire logic [7:0] io_in,
  input wire logic rb_in
);
  nbi_pkg::nbi_host_reg_type r;
  nbi_pkg::nbi_host_reg_type next_r;
  logic fifo_ready;
  logic pop_valid;
  logic pop_ready;
  logic [34:0] pop_data;
  logic [2:0] pk;
  logic [31:0] pd;
  logic go;

  // Address byte for one of the five cycles, unused bits forced low
  function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [2:0] i);
    case (i)
      3'h0: addr_byte = a[7:0];
      3'h1: addr_byte = {4'h0, a[11:8]};
      3'h2: addr_byte = a[19:12];
      3'h3: addr_byte = a[27:20];
      default: addr_byte = {4'h0, a[31:28]};
    endcase
  endfunction : addr_byte

  // Opcodes that a busy device still takes
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == nbi_pkg::OP_RESET) || (op == nbi_pkg::OP_STATUS);
  endfunction : busy_ok

  // Requests queue here so the user side can run ahead of the bus
  nbi_fifo #(
    .WIDTH(nbi_pkg::FIFO_WIDTH),
    .DEPTH(nbi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(mclk_in),
    .nrst_in(nrst_in),
    .en_in(clk_en_in),
    .push_valid_in(req_valid_in),
    .push_ready_out(fifo_ready),
    .push_data_in({req_kind_in, req_data_in}),
    .pop_valid_out(pop_valid),
    .pop_ready_in(pop_ready),
    .pop_data_out(pop_data)
  );

  assign pk = pop_data[34:32];
  assign pd = pop_data[31:0];

  // Hold a command back while busy unless it is reset or status
  always_comb begin
    go = 1'b0;
    if (r.st == nbi_pkg::ST_IDLE && pop_valid) begin
      go = (pk != nbi_pkg::KIND_CMD) || r.rb || busy_ok(pd[7:0]);
    end
  end
  assign pop_ready = go;

  // Sequencer
  always_comb begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.rb = rb_in; // Wired-or line, low when any device busy
    next_r.wp_n = modify_en_in; // Lock stays low unless modify allowed
    next_r.busy = ~rb_in; // Own flop, so the flag is not a gate behind one
    // Fill count shadows the queue so ready can leave from a flop; six extra
    // bits buy a pin with no logic between it and the register
    if (req_valid_in && fifo_ready) begin
      next_r.fill = next_r.fill + 6'h01;
    end
    if (go) begin
      next_r.fill = next_r.fill - 6'h01;
    end
    next_r.rdy = (next_r.fill != 6'(nbi_pkg::FIFO_DEPTH)); // Full one edge ahead
    case (r.st)
      nbi_pkg::ST_IDLE: begin
        if (go) begin
          next_r.kind = pk;
          next_r.cnt = '0;
          case (pk)
            nbi_pkg::KIND_CMD: begin
              next_r.ce_n = 1'b0;
              next_r.cle = 1'b1; // Only one qualifier at a time
              next_r.ale = 1'b0;
              next_r.io = pd[7:0];
              next_r.oe = 1'b1;
              next_r.we_n = 1'b0;
              next_r.plane2 = (pd[7:0] == nbi_pkg::OP_PROG_PLANE2);
              next_r.st = nbi_pkg::ST_WLO;
            end
            nbi_pkg::KIND_ADDR: begin
              // Second-plane page after the plane-two opcode
              next_r.addr = r.plane2 ? (pd | nbi_pkg::PLANE_BIT) : pd;
              next_r.ce_n = 1'b0;
              next_r.cle = 1'b0;
              next_r.ale = 1'b1;
              next_r.io = addr_byte(r.plane2 ? (pd | nbi_pkg::PLANE_BIT) : pd, 3'h0);
              next_r.oe = 1'b1;
              next_r.we_n = 1'b0;
              next_r.st = nbi_pkg::ST_WLO;
            end
            nbi_pkg::KIND_DWR: begin
              next_r.ce_n = 1'b0;
              next_r.cle = 1'b0;
              next_r.ale = 1'b0; // Both low for data
              next_r.io = pd[7:0];
              next_r.oe = 1'b1;
              next_r.we_n = 1'b0;
              next_r.st = nbi_pkg::ST_WLO;
            end
            nbi_pkg::KIND_DRD: begin
              next_r.ce_n = 1'b0;
              next_r.cle = 1'b0;
              next_r.ale = 1'b0;
              next_r.oe = 1'b0; // Bus released to the device
              next_r.re_n = 1'b0;
              next_r.st = nbi_pkg::ST_RLO;
            end
            nbi_pkg::KIND_WAIT: begin
              next_r.st = nbi_pkg::ST_WAIT;
            end
            nbi_pkg::KIND_STBY: begin
              next_r.ce_n = 1'b1;
              next_r.st = nbi_pkg::ST_STBY;
            end
            default: begin
              next_r.st = nbi_pkg::ST_IDLE; // Unknown kinds are dropped
            end
          endcase
        end
      end
      nbi_pkg::ST_WLO: begin
        next_r.we_n = 1'b1; // Rising edge captures the byte
        next_r.st = nbi_pkg::ST_WHI;
      end
      nbi_pkg::ST_WHI: begin
        // Byte and qualifiers held one cycle past the rising edge
        if (r.kind == nbi_pkg::KIND_ADDR && r.cnt[2:0] != nbi_pkg::ADDR_LAST) begin
          next_r.cnt = r.cnt + 8'h01;
          next_r.io = addr_byte(r.addr, r.cnt[2:0] + 3'h1);
          next_r.we_n = 1'b0;
          next_r.st = nbi_pkg::ST_WLO;
        end else begin
          next_r.cle = 1'b0;
          next_r.ale = 1'b0;
          next_r.oe = 1'b0;
          next_r.st = nbi_pkg::ST_IDLE;
        end
      end
      nbi_pkg::ST_RLO: begin
        // Sample only after the output-valid delay has passed
        if (r.cnt + 8'h01 >= nbi_pkg::OUT_VALID_CYC) begin
          next_r.rd_data = io_in;
          next_r.rd_valid = 1'b1;
          next_r.re_n = 1'b1;
          next_r.cnt = '0;
          next_r.st = nbi_pkg::ST_RHI;
        end else begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      nbi_pkg::ST_RHI: begin
        next_r.st = nbi_pkg::ST_IDLE; // High phase keeps strobe pulses wide
      end
      nbi_pkg::ST_WAIT: begin
        // Line may lag the command, so give it time to fall first
        if (r.cnt < nbi_pkg::BUSY_SETTLE_CYC) begin
          next_r.cnt = r.cnt + 8'h01;
        end else if (r.rb) begin
          next_r.st = nbi_pkg::ST_IDLE;
        end
      end
      nbi_pkg::ST_STBY: begin
        if (r.cnt + 8'h01 >= nbi_pkg::STANDBY_CYC) begin
          next_r.st = nbi_pkg::ST_IDLE;
        end else begin
          next_r.cnt = r.cnt + 8'h01;
        end
      end
      default: begin
        next_r = r;
        next_r.st = nbi_pkg::ST_IDLE;
      end
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '{st: nbi_pkg::ST_IDLE, ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
             we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0, oe: 1'b0, rb: 1'b1,
             plane2: 1'b0, rd_valid: 1'b0, io: 8'h00, rd_data: 8'h00,
             cnt: 8'h00, kind: 3'h0, addr: 32'h0000_0000, busy: 1'b0,
             rdy: 1'b1, fill: 6'h00};
    end else if (clk_en_in) begin
      r <= next_r;
    end
  end

  // Every pin leaves straight from the state register; ready matches
  // the queue's own full flag, so no slot is held back
  assign req_ready_out = r.rdy;
  assign rd_data_out = r.rd_data;
  assign rd_valid_out = r.rd_valid;
  assign busy_out = r.busy;
  assign ce_n_out = r.ce_n;
  assign cle_out = r.cle;
  assign ale_out = r.ale;
  assign we_n_out = r.we_n;
  assign re_n_out = r.re_n;
  assign wp_n_out = r.wp_n;
  assign io_out = r.io;
  assign io_oe_out = r.oe;
endmodule : nbi_host

`default_nettype wire

// ===== test/nbi_host_props.sv
// Pin-level checker for the NAND bus host
`timescale 1ns/1ps
`default_nettype none
module nbi_host_props (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic modify_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic busy_out,
  input wire logic ce_n_out,
  input wire logic cle_out,
  input wire logic ale_out,
  input wire logic we_n_out,
  input wire logic re_n_out,
  input wire logic wp_n_out,
  input wire logic [7:0] io_out,
  input wire logic io_oe_out,
  input wire logic [7:0] io_in,
  input wire logic rb_in
);
  // ****
  // Bus cycle shape
  // ****
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  chk_one_qualifier: assert property (!(cle_out && ale_out))
    else $error("both qualifiers high");
  chk_strobes_apart: assert property (!(!we_n_out && !re_n_out))
    else $error("both strobes low");
  chk_write_pulse: assert property ($fell(we_n_out) |=> we_n_out)
    else $error("write strobe low too long");
  chk_write_setup: assert property (!we_n_out |-> !ce_n_out && io_oe_out && re_n_out)
    else $error("write cycle badly qualified");
  chk_read_setup: assert property (!re_n_out |-> !ce_n_out && !io_oe_out && !cle_out && !ale_out)
    else $error("read cycle badly qualified");
  // Byte taken at the end of the low phase, so the device delay is covered
  chk_read_sample: assert property ($fell(re_n_out) |=> rd_valid_out && rd_data_out == $past(io_in))
    else $error("read byte not delivered");
  chk_lock_copy: assert property ($past(nrst_in) && $past(clk_en_in) |-> wp_n_out == $past(modify_en_in))
    else $error("lock pin does not follow");
  chk_busy_copy: assert property ($past(nrst_in) && $past(clk_en_in) |-> busy_out == !$past(rb_in))
    else $error("busy flag does not follow");
  chk_busy_gate: assert property (busy_out && cle_out && !we_n_out |-> io_out == 8'hff || io_out == 8'h70)
    else $error("command sent to busy device");
  chk_standby_hold: assert property ($rose(ce_n_out) |=> ce_n_out [*8])
    else $error("standby too short");
endmodule : nbi_host_props

bind nbi_host nbi_host_props u_props (.mclk_in(mclk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
  .modify_en_in(modify_en_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
  .busy_out(busy_out), .ce_n_out(ce_n_out), .cle_out(cle_out), .ale_out(ale_out),
  .we_n_out(we_n_out), .re_n_out(re_n_out), .wp_n_out(wp_n_out), .io_out(io_out),
  .io_oe_out(io_oe_out), .io_in(io_in), .rb_in(rb_in));
`default_nettype wire

// ===== test/nbi_flash_model.sv
// Behavioural NAND device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nbi_flash_model #(
  parameter int BUSY_CYC = 200,
  parameter int OUTPUT_VALID_DELAY_NS = 20,
  parameter int GLITCH_NS = 5,
  parameter logic [7:0] ID_BYTE = 8'h5a // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic ce_n_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic wp_n_in,
  input wire logic [7:0] io_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  output logic rb_pull_out
);
  logic [7:0] mem [16];
  logic [7:0] pbuf [16];
  logic [7:0] abyte [5];
  logic [7:0] cmd = 8'h00;
  int acnt = 0;
  logic [3:0] col = 4'h0;
  logic fail = 1'b0;
  logic stat_mode = 1'b0;
  int busy_cnt = 0;
  int bad_cmd = 0;
  int glitches = 0;
  realtime we_fall = 0.0;
  // Start of each write strobe pulse, to spot pulses too short to count
  always @(negedge we_n_in) we_fall = $realtime;
  // Bytes land on the strobe rise; busy runs on whatever select does
  always @(posedge we_n_in) begin
    if (!ce_n_in && $realtime - we_fall < GLITCH_NS) begin
      glitches++; // Too short to count as a write
    end else if (!ce_n_in && cle_in) begin
      if (busy_cnt != 0 && io_in != 8'hff && io_in != 8'h70) begin
        bad_cmd++;
      end else begin
        cmd = io_in;
        stat_mode = (io_in == 8'h70);
        acnt = 0;
        if (io_in == 8'h30 || io_in == 8'he0) col = abyte[0][3:0];
        if (io_in == 8'h30) busy_cnt = BUSY_CYC;
        if (io_in == 8'hff) busy_cnt = 2;
        // Lock low refuses the modify and flags it
        if (io_in == 8'h10 || io_in == 8'hd0) begin
          fail = !wp_n_in;
          busy_cnt = wp_n_in ? BUSY_CYC : 0;
          if (wp_n_in && io_in == 8'h10) mem = pbuf;
        end
      end
    end else if (!ce_n_in && ale_in && acnt < 5) begin
      abyte[acnt] = io_in;
      if (acnt == 0) col = io_in[3:0];
      acnt++;
    end else if (!ce_n_in && !ale_in) begin
      pbuf[col] = io_in;
      col++;
    end
  end
  // Busy count runs off the bench clock; open drain only pulls low
  always @(posedge clk_in) begin
    if (busy_cnt > 0) busy_cnt <= busy_cnt - 1; // Late update keeps host sample clean
  end
  assign rb_pull_out = (busy_cnt != 0);
  // Garbage until the valid delay runs out, then the next byte
  always @(negedge re_n_in) begin
    if (!ce_n_in) begin
      dq_out = ~dq_out;
      dq_out <= #(OUTPUT_VALID_DELAY_NS) stat_mode ? {wp_n_in, busy_cnt == 0, 5'h00, fail} :
        (cmd == 8'h90) ? ID_BYTE : mem[col];
      if (!stat_mode) col++;
    end
  end
  assign dq_oe_out = !ce_n_in && !re_n_in; // Floats when deselected
  initial begin
    dq_out = 8'h00;
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
  end
endmodule : nbi_flash_model
`default_nettype wire

// ===== test/test_nand_async_bus_interface.sv
// Self-checking bench for the NAND bus host
`timescale 1ns/1ps
`default_nettype none
module test_nand_async_bus_interface;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic [2:0] req_kind_in = 3'h0;
  logic [31:0] req_data_in = 32'h0000_0000;
  logic modify_en_in = 1'b1;
  logic req_ready_out, rd_valid_out, busy_out, ce_n_out, cle_out, ale_out;
  logic we_n_out, re_n_out, wp_n_out, io_oe_out, dev_oe, dev_pull;
  logic [7:0] rd_data_out, io_out, dev_dq, io_bus, st;
  logic [7:0] last_bus = 8'h00;
  logic [7:0] pd [4];
  logic [7:0] wd [4];
  logic [7:0] rq [$];
  logic [31:0] a;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 6;
  int cycles = 0;
  int n;
  always #25 mclk_in = ~mclk_in;
  // Released bus shows a changing pattern, never a stale byte
  assign io_bus = io_oe_out ? io_out : dev_oe ? dev_dq : ~last_bus;
  always @(posedge mclk_in) last_bus <= io_bus;
  nbi_host DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .req_valid_in(req_valid_in), .req_kind_in(req_kind_in), .req_data_in(req_data_in),
    .req_ready_out(req_ready_out), .modify_en_in(modify_en_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .busy_out(busy_out), .ce_n_out(ce_n_out), .cle_out(cle_out),
    .ale_out(ale_out), .we_n_out(we_n_out), .re_n_out(re_n_out), .wp_n_out(wp_n_out),
    .io_out(io_out), .io_oe_out(io_oe_out), .io_in(io_bus), .rb_in(!dev_pull));
  nbi_flash_model u_flash (.clk_in(mclk_in), .ce_n_in(ce_n_out), .cle_in(cle_out),
    .ale_in(ale_out), .we_n_in(we_n_out), .re_n_in(re_n_out), .wp_n_in(wp_n_out),
    .io_in(io_bus), .dq_out(dev_dq), .dq_oe_out(dev_oe), .rb_pull_out(dev_pull));
  // ****
  // Helpers
  // ****
  always @(posedge mclk_in) if (rd_valid_out === 1'b1) rq.push_back(rd_data_out);
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] exp_abyte(input logic [31:0] v, input int i);
    case (i)
      0: return v[7:0];
      1: return {4'h0, v[11:8]};
      2: return v[19:12];
      3: return v[27:20];
      default: return {4'h0, v[31:28]};
    endcase
  endfunction : exp_abyte
  // A clock edge always passes before valid rises again
  task automatic push(input logic [2:0] k, input logic [31:0] d);
    @(posedge mclk_in);
    #1 req_kind_in = k;
    req_data_in = d;
    req_valid_in = 1'b1;
    do @(posedge mclk_in); while (req_ready_out !== 1'b1);
    #1 req_valid_in = 1'b0;
  endtask : push
  task automatic take(output logic [7:0] b);
    for (int i = 0; i < 2000 && rq.size() == 0; i++) @(posedge mclk_in);
    b = (rq.size() > 0) ? rq.pop_front() : 8'hxx;
  endtask : take
  task automatic sync(output logic [7:0] s);
    push(nbi_pkg::KIND_WAIT, 0);
    push(nbi_pkg::KIND_CMD, 8'h70);
    push(nbi_pkg::KIND_DRD, 0);
    take(s);
    #1 check({1'b0, s[6], 6'h00}, 8'h40);
  endtask : sync
  task automatic readback();
    push(nbi_pkg::KIND_CMD, 8'h00);
    push(nbi_pkg::KIND_ADDR, a);
    push(nbi_pkg::KIND_CMD, 8'h30);
    push(nbi_pkg::KIND_WAIT, 0);
    for (int i = 0; i < 4; i++) push(nbi_pkg::KIND_DRD, 0);
    for (int i = 0; i < 4; i++) begin
      take(st);
      check(st, wd[i]);
    end
    push(nbi_pkg::KIND_CMD, 8'h05);
    push(nbi_pkg::KIND_ADDR, a);
    push(nbi_pkg::KIND_CMD, 8'he0);
    push(nbi_pkg::KIND_DRD, 0);
    take(st);
    check(st, wd[0]);
  endtask : readback
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (20) @(posedge mclk_in);
    #1 nrst_in = 1'b1;
    push(nbi_pkg::KIND_CMD, 8'hff);
    push(nbi_pkg::KIND_CMD, 8'h90);
    push(nbi_pkg::KIND_DRD, 0);
    take(st);
    check(st, u_flash.ID_BYTE);
    // All-ones corner shows the forced-low nibbles; last pass is the second plane
    for (int j = 0; j < 3; j++) begin
      a = (j == 0) ? 32'hffff_ffff : $random(seed);
      push(nbi_pkg::KIND_CMD, (j == 2) ? 8'h81 : 8'h80);
      push(nbi_pkg::KIND_ADDR, a & ~nbi_pkg::PLANE_BIT);
      sync(st);
      a = (j == 2) ? (a | nbi_pkg::PLANE_BIT) : (a & ~nbi_pkg::PLANE_BIT);
      for (int i = 0; i < 5; i++) check(u_flash.abyte[i], exp_abyte(a, i));
    end
    // Program then read back; locked pass must leave old data
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) pd[i] = 8'($random(seed));
      if (p == 0) wd = pd;
      push(nbi_pkg::KIND_CMD, 8'h80);
      push(nbi_pkg::KIND_ADDR, a);
      for (int i = 0; i < 4; i++) push(nbi_pkg::KIND_DWR, {24'h00_0000, pd[i]});
      sync(st);
      modify_en_in = (p == 0);
      push(nbi_pkg::KIND_CMD, 8'h10);
      sync(st);
      check({7'h00, st[0]}, 8'(p));
      modify_en_in = 1'b1;
      readback();
    end
    // Dual-plane erase, status while busy, then fill the queue behind it
    for (int i = 0; i < 2; i++) begin
      push(nbi_pkg::KIND_CMD, 8'h60);
      push(nbi_pkg::KIND_ADDR, a ^ (i * nbi_pkg::PLANE_BIT));
    end
    push(nbi_pkg::KIND_CMD, 8'hd0);
    push(nbi_pkg::KIND_CMD, 8'h70);
    push(nbi_pkg::KIND_DRD, 0);
    take(st);
    check({1'b0, st[6], 6'h00}, 8'h00);
    n = 0;
    #1 while (req_ready_out === 1'b1 && n < 40) begin
      push(nbi_pkg::KIND_CMD, 8'h00);
      n++;
    end
    check(8'(n), 8'h20);
    sync(st);
    check(8'(u_flash.bad_cmd), 8'h00);
    check(8'(u_flash.glitches), 8'h00);
    clk_en_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 clk_en_in = 1'b1;
    push(nbi_pkg::KIND_STBY, 0);
    sync(st);
    give_verdict();
  end
endmodule : test_nand_async_bus_interface
`default_nettype wire
